// File: csa_pkg.sv
// package of widths, select codes and carriers for the cascadable slice datapath
package csa_pkg;

	// datapath widths
	localparam int unsigned CSA_A_W = 25;
	localparam int unsigned CSA_B_W = 18;
	localparam int unsigned CSA_AB_W = 48;
	localparam int unsigned CSA_C_W = 48;
	localparam int unsigned CSA_P_W = 48;
	localparam int unsigned CSA_SUM_W = 50;
	localparam int unsigned CSA_SHIFT = 17;
	localparam int unsigned CSA_P_MSB = 47;
	localparam int unsigned CSA_OVF_BIT = 46;

	// operand-select codes named by their common jobs
	localparam logic [6:0] CSA_OPSEL_ACC_ABC = 7'h2F;
	localparam logic [6:0] CSA_OPSEL_ACC_AB = 7'h23;
	localparam logic [6:0] CSA_OPSEL_MULTIPLY_ACCUMULATE_EXT = 7'h48;
	localparam logic [6:0] CSA_OPSEL_MADD = 7'h35;

	// x multiplexer codes, operand-select bits 1:0
	localparam logic [1:0] CSA_X_ZERO = 2'h0;
	localparam logic [1:0] CSA_X_M = 2'h1;
	localparam logic [1:0] CSA_X_P = 2'h2;
	localparam logic [1:0] CSA_X_AB = 2'h3;

	// y multiplexer codes, operand-select bits 3:2
	localparam logic [1:0] CSA_Y_ZERO = 2'h0;
	localparam logic [1:0] CSA_Y_M = 2'h1;
	localparam logic [1:0] CSA_Y_ONES = 2'h2;
	localparam logic [1:0] CSA_Y_C = 2'h3;

	// z multiplexer codes, operand-select bits 6:4
	localparam logic [2:0] CSA_Z_ZERO = 3'h0;
	localparam logic [2:0] CSA_Z_PCIN = 3'h1;
	localparam logic [2:0] CSA_Z_P = 3'h2;
	localparam logic [2:0] CSA_Z_C = 3'h3;
	localparam logic [2:0] CSA_Z_P_EXT = 3'h4;
	localparam logic [2:0] CSA_Z_PCIN_SHR = 3'h5;
	localparam logic [2:0] CSA_Z_P_SHR = 3'h6;

	// arithmetic-function codes
	localparam logic [3:0] CSA_ALU_ADD = 4'h0;
	localparam logic [3:0] CSA_ALU_NSUB = 4'h1;
	localparam logic [3:0] CSA_ALU_NADD = 4'h2;
	localparam logic [3:0] CSA_ALU_SUB = 4'h3;

	// carry-in source codes
	localparam logic [2:0] CSA_CI_FABRIC = 3'h0;
	localparam logic [2:0] CSA_CI_PCIN_RND = 3'h1;
	localparam logic [2:0] CSA_CI_CASCADE = 3'h2;
	localparam logic [2:0] CSA_CI_P_RND = 3'h3;

	// reset value of the result register; the other registers reset to zero
	localparam logic [47:0] CSA_P_RST = 48'h0;

	// dynamic control word from the fabric
	typedef struct packed {
		logic [6:0] operand_select_code;
		logic [3:0] arith_function_code;
		logic [2:0] carry_in_source_select;
	} csa_ctrl_t;

	// status flags beside the result
	typedef struct packed {
		logic overflow;
		logic underflow;
		logic pattern_match;
		logic pattern_match_b;
		logic multiply_accumulate_ext_active;
	} csa_flags_t;

endpackage

// File: csa_mult.sv
// two-stage registered signed multiplier feeding the slice adder
`timescale 1ns/1ns
module csa_mult
	import csa_pkg::*;
#(
	parameter int unsigned AW = CSA_A_W,
	parameter int unsigned BW = CSA_B_W,
	parameter int unsigned PW = CSA_P_W
) (
	input wire logic clk_i, // slice clock
	input wire logic rst_n_i, // synchronous reset, low
	input wire logic [AW-1:0] a_i, // multiplicand
	input wire logic [BW-1:0] b_i, // multiplier
	output logic [PW-1:0] m_o // sign-extended product
);

	logic [AW-1:0] a_ff;
	logic [BW-1:0] b_ff;
	logic [PW-1:0] m_ff;
	logic signed [AW+BW-1:0] prod;
	logic [PW-1:0] nxt_m;

	// full-width product sign-extended to the adder width
	assign prod = $signed(a_ff) * $signed(b_ff);
	assign nxt_m = {{(PW-AW-BW){prod[AW+BW-1]}}, prod};
	assign m_o = m_ff;

	// input register then product register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			a_ff <= '0;
			b_ff <= '0;
			m_ff <= '0;
		end else begin
			a_ff <= a_i;
			b_ff <= b_i;
			m_ff <= nxt_m; // product only spans AW+BW bits
		end
	end

endmodule

// File: csa_slice.sv
// cascadable multiply-add slice: operand muxes, add/sub unit, cascade and flags
//
// Contract
// - code 0101111 with 0011 gives P minus (A:B plus C plus carry).
// - add/sub may flip each cycle between 0000 and 0011, no reconfiguration.
// - chained wide adder with 0000 gives C plus A:B.
// - chained wide adder with 0011 gives C minus A:B.
// - 96-bit accumulate without C: 0100011 and 0000 give P plus A:B plus carry.
// - 96-bit accumulate via C: 0101111 and 0000 give P plus A:B plus C plus carry.
// - first slice holds low 48 bits, second high; carry cascades between.
// - 43-bit product: flag overflow past bit 46, pattern-detect past bit 47.
// - code 1001000 adds own P to the lower slice product sign cascade; with OPSEL_REG=1 it adds only the carry to P.
// - extension mode is entered only right after reset.
// - 25x18 complex multiply uses four alike slices, only adder differs.
// - final stage subtracts for real, adds for imaginary.
// - 35-bit operand split 34:17 and 16:0; lower product shifted right 17.
// - complex accumulate runs N-1 cycles; operand select changes on the last.
// - cross terms combine only after the requested accumulate cycles.
`timescale 1ns/1ns
module csa_slice
	import csa_pkg::*;
#(
	parameter int unsigned OPSEL_REG = 1, // operand_select_pipe_cfg
	parameter int unsigned CISEL_REG = 1, // carry_select_pipe_cfg
	parameter int unsigned AB_PIPE = 1 // 1 or 2 register stages on A:B
) (
	input wire logic clk_i, // slice clock
	input wire logic rst_n_i, // synchronous reset, low
	input wire logic [CSA_A_W-1:0] a_i, // A operand
	input wire logic [CSA_B_W-1:0] b_i, // B operand
	input wire logic [CSA_C_W-1:0] c_i, // C operand
	input wire logic carry_in_i, // fabric carry input
	input wire csa_ctrl_t ctrl_i, // dynamic select codes
	input wire logic [CSA_P_W-1:0] pcin_i, // cascaded result from lower slice
	input wire logic carry_cascade_in_i, // cascaded carry from lower slice
	input wire logic product_sign_cascade_i, // product sign from lower slice
	input wire logic [CSA_P_W-1:0] pattern_i, // pattern detector value
	input wire logic [CSA_P_W-1:0] mask_i, // pattern detector mask, 1 ignores
	output logic [CSA_P_W-1:0] p_o, // accumulated result, also cascade out
	output logic cascaded_carry_out_o, // carry or borrow to upper slice
	output logic product_sign_cascade_o, // sign of product term added
	output csa_flags_t flags_o // overflow, underflow and match flags
);

	// multiply_accumulate extension arming state
	typedef enum logic [1:0] {
		CSA_EXT_ARMED = 2'b00,
		CSA_EXT_ON = 2'b01,
		CSA_EXT_LOCKED = 2'b10
	} csa_ext_st_t;

	csa_ext_st_t ext_st_ff;
	csa_ext_st_t nxt_ext_st;

	// registers
	logic [CSA_P_W-1:0] p_ff;
	logic [CSA_P_W-1:0] nxt_p;
	logic cco_ff;
	logic nxt_cco;
	logic psc_ff;
	logic nxt_psc;
	csa_flags_t flags_ff;
	csa_flags_t nxt_flags;
	logic [6:0] opsel_ff;
	logic [3:0] alu_ff;
	logic [2:0] cisel_ff;
	logic carry_in_ff;
	logic [CSA_AB_W-1:0] ab_q1_ff;
	logic [CSA_AB_W-1:0] ab_q2_ff;
	logic [CSA_C_W-1:0] c_ff;

	// effective controls and operands
	logic [6:0] opsel;
	logic [3:0] alu;
	logic [2:0] cisel;
	logic cin_fabric;
	logic [CSA_AB_W-1:0] ab_cat;
	logic [CSA_AB_W-1:0] ab_op;
	logic [CSA_P_W-1:0] m_op;
	logic [1:0] x_code;
	logic [1:0] y_code;
	logic [2:0] z_code;
	logic ext_sel;
	logic ext_ok;
	logic [CSA_P_W-1:0] x_val;
	logic [CSA_P_W-1:0] y_val;
	logic [CSA_P_W-1:0] z_val;
	logic cin;
	logic m_used;

	// adder
	logic [CSA_SUM_W-1:0] w_sum;
	logic [CSA_SUM_W-1:0] z_ext;
	logic [CSA_SUM_W-1:0] r_add;
	logic [CSA_SUM_W-1:0] r_sub;
	logic [CSA_SUM_W-1:0] r_nsub;
	logic [CSA_SUM_W-1:0] result;
	logic carry_res;

	// pattern detection and overflow
	logic [CSA_P_W-1:0] pd_diff;
	logic [CSA_P_W-1:0] pd_diff_b;
	logic p_in_range;

	// product from the two-stage multiplier
	csa_mult #(
		.AW(CSA_A_W),
		.BW(CSA_B_W),
		.PW(CSA_P_W)
	) u_mult (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.a_i(a_i),
		.b_i(b_i),
		.m_o(m_op)
	);

	// pipelined or direct select codes, chosen per configuration
	assign opsel = (OPSEL_REG != 0) ? opsel_ff : ctrl_i.operand_select_code;
	assign alu = (OPSEL_REG != 0) ? alu_ff : ctrl_i.arith_function_code;
	assign cisel = (CISEL_REG != 0) ? cisel_ff : ctrl_i.carry_in_source_select;
	assign cin_fabric = (CISEL_REG != 0) ? carry_in_ff : carry_in_i;

	// concatenated A:B, one or two register stages for cascade alignment
	assign ab_cat = {{(CSA_AB_W-CSA_A_W-CSA_B_W){1'b0}}, a_i, b_i}; // 43 bits zero-extended
	assign ab_op = (AB_PIPE > 1) ? ab_q2_ff : ab_q1_ff;

	// field decode of the operand-select code
	assign x_code = opsel[1:0];
	assign y_code = opsel[3:2];
	assign z_code = opsel[6:4];
	assign ext_sel = (opsel == CSA_OPSEL_MULTIPLY_ACCUMULATE_EXT);
	assign ext_ok = ext_sel && (ext_st_ff != CSA_EXT_LOCKED);
	assign m_used = (x_code == CSA_X_M);

	// x operand
	always_comb begin
		case (x_code)
			CSA_X_ZERO: x_val = '0;
			CSA_X_M: x_val = m_op;
			CSA_X_P: x_val = p_ff;
			CSA_X_AB: x_val = ab_op;
			default: x_val = '0;
		endcase
	end

	// y operand; the extension mode puts the lower product sign here
	always_comb begin
		case (y_code)
			CSA_Y_ZERO: y_val = '0;
			CSA_Y_M: y_val = '0; // product already on x
			CSA_Y_ONES: begin
				if (ext_sel) begin
					y_val = ext_ok ? {CSA_P_W{product_sign_cascade_i}} : '0;
				end else begin
					y_val = '1;
				end
			end
			CSA_Y_C: y_val = c_ff;
			default: y_val = '0;
		endcase
	end

	// z operand, including the shifted cascade for partial products
	always_comb begin
		case (z_code)
			CSA_Z_ZERO: z_val = '0;
			CSA_Z_PCIN: z_val = pcin_i;
			CSA_Z_P: z_val = p_ff;
			CSA_Z_C: z_val = c_ff;
			CSA_Z_P_EXT: z_val = p_ff;
			CSA_Z_PCIN_SHR: begin
				z_val = {{CSA_SHIFT{pcin_i[CSA_P_MSB]}}, pcin_i[CSA_P_MSB:CSA_SHIFT]};
			end
			CSA_Z_P_SHR: begin
				z_val = {{CSA_SHIFT{p_ff[CSA_P_MSB]}}, p_ff[CSA_P_MSB:CSA_SHIFT]};
			end
			default: z_val = '0;
		endcase
	end

	// carry-in source
	always_comb begin
		case (cisel)
			CSA_CI_FABRIC: cin = cin_fabric;
			CSA_CI_PCIN_RND: cin = ~pcin_i[CSA_P_MSB];
			CSA_CI_CASCADE: cin = carry_cascade_in_i;
			CSA_CI_P_RND: cin = ~p_ff[CSA_P_MSB];
			default: cin = 1'b0;
		endcase
	end

	// unsigned sum of x, y and carry; z added or subtracted around it
	assign w_sum = {2'b00, x_val} + {2'b00, y_val} + {{(CSA_SUM_W-1){1'b0}}, cin};
	assign z_ext = {2'b00, z_val};
	assign r_add = z_ext + w_sum;
	assign r_sub = z_ext - w_sum;
	assign r_nsub = w_sum - z_ext - {{(CSA_SUM_W-1){1'b0}}, 1'b1};

	// arithmetic function select; changes take effect on the next edge
	always_comb begin
		case (alu)
			CSA_ALU_ADD: begin
				result = r_add;
				carry_res = r_add[CSA_P_W]; // only one carry: no 3-input extension
			end
			CSA_ALU_SUB: begin
				result = r_sub;
				carry_res = r_sub[CSA_SUM_W-1]; // borrow feeds upper subtract
			end
			CSA_ALU_NSUB: begin
				result = r_nsub;
				carry_res = r_nsub[CSA_SUM_W-1];
			end
			CSA_ALU_NADD: begin
				result = ~r_add;
				carry_res = r_add[CSA_P_W];
			end
			default: begin
				result = r_add;
				carry_res = r_add[CSA_P_W];
			end
		endcase
	end

	// next result, cascade carry and product sign
	assign nxt_p = result[CSA_P_W-1:0]; // low 48 bits held here
	assign nxt_cco = carry_res;
	assign nxt_psc = m_used & m_op[CSA_P_MSB];

	// pattern detector over the next result and its complement
	assign pd_diff = (nxt_p ^ pattern_i) & ~mask_i;
	assign pd_diff_b = (~nxt_p ^ pattern_i) & ~mask_i;

	// overflow past bit 46 seen when the top two bits split from in-range
	assign p_in_range = (p_ff[CSA_P_MSB] == p_ff[CSA_OVF_BIT]);
	assign nxt_flags.overflow = p_in_range && !nxt_p[CSA_P_MSB] && nxt_p[CSA_OVF_BIT];
	assign nxt_flags.underflow = p_in_range && nxt_p[CSA_P_MSB] && !nxt_p[CSA_OVF_BIT];
	assign nxt_flags.pattern_match = (pd_diff == '0);
	assign nxt_flags.pattern_match_b = (pd_diff_b == '0);
	assign nxt_flags.multiply_accumulate_ext_active = ext_ok;

	// extension arming: only the first select after reset may enter it
	always_comb begin
		case (ext_st_ff)
			CSA_EXT_ARMED: begin
				nxt_ext_st = ext_sel ? CSA_EXT_ON : CSA_EXT_LOCKED;
			end
			CSA_EXT_ON: begin
				nxt_ext_st = ext_sel ? CSA_EXT_ON : CSA_EXT_LOCKED;
			end
			CSA_EXT_LOCKED: nxt_ext_st = CSA_EXT_LOCKED;
			default: nxt_ext_st = CSA_EXT_LOCKED;
		endcase
	end

	// outputs straight from registers
	assign p_o = p_ff;
	assign cascaded_carry_out_o = cco_ff;
	assign product_sign_cascade_o = psc_ff;
	assign flags_o = flags_ff;

	// select-code and carry pipeline registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			opsel_ff <= 7'h00;
			alu_ff <= 4'h0;
			cisel_ff <= 3'h0;
			carry_in_ff <= 1'b0;
		end else begin
			opsel_ff <= ctrl_i.operand_select_code;
			alu_ff <= ctrl_i.arith_function_code;
			cisel_ff <= ctrl_i.carry_in_source_select;
			carry_in_ff <= carry_in_i;
		end
	end

	// operand registers: C once, A:B once or twice
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ab_q1_ff <= '0;
			ab_q2_ff <= '0;
			c_ff <= '0;
		end else begin
			ab_q1_ff <= ab_cat;
			ab_q2_ff <= ab_q1_ff;
			c_ff <= c_i;
		end
	end

	// result, cascade and flag registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			p_ff <= CSA_P_RST;
			cco_ff <= 1'b0;
			psc_ff <= 1'b0;
			flags_ff <= '0;
			ext_st_ff <= CSA_EXT_ARMED;
		end else begin
			p_ff <= nxt_p;
			cco_ff <= nxt_cco;
			psc_ff <= nxt_psc; // aligned with cco for extension
			flags_ff <= nxt_flags;
			ext_st_ff <= nxt_ext_st;
		end
	end

endmodule

// File: csa_slice_sva.sv
// checker for the cascadable slice datapath
`timescale 1ns/1ns
module csa_slice_sva
	import csa_pkg::*;
#(
	parameter int unsigned OPSEL_REG = 1,
	parameter int unsigned CISEL_REG = 1
) (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // reset, low
	input wire logic [CSA_A_W-1:0] a_i, // A
	input wire logic [CSA_B_W-1:0] b_i, // B
	input wire logic [CSA_C_W-1:0] c_i, // C
	input wire logic carry_in_i, // fabric carry
	input wire csa_ctrl_t ctrl_i, // codes
	input wire logic carry_cascade_in_i, // carry from below
	input wire logic product_sign_cascade_i, // sign from below
	input wire logic [CSA_P_W-1:0] pattern_i, // pattern
	input wire logic [CSA_P_W-1:0] mask_i, // mask
	input wire logic [CSA_P_W-1:0] p_o, // result
	input wire logic cascaded_carry_out_o, // carry out
	input wire csa_flags_t flags_o // flags
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// operand views; piped means results land two edges after the pins
	wire logic [47:0] ab = 48'({a_i, b_i});
	wire logic [6:0] op = ctrl_i.operand_select_code;
	wire logic add = ctrl_i.arith_function_code == CSA_ALU_ADD;
	wire logic sub = ctrl_i.arith_function_code == CSA_ALU_SUB;
	wire logic piped = OPSEL_REG == 1 && CISEL_REG == 1;
	wire logic fab = piped && ctrl_i.carry_in_source_select == CSA_CI_FABRIC;
	wire logic casc = ctrl_i.carry_in_source_select == CSA_CI_CASCADE;

	a_sub_acc_abc: assert property (fab && op == CSA_OPSEL_ACC_ABC && sub |-> ##2
		p_o == $past(p_o) - ($past(ab, 2) + $past(c_i, 2) + $past(carry_in_i, 2)))
		else $error("accumulate subtract result wrong");
	a_add_acc_abc: assert property (fab && op == CSA_OPSEL_ACC_ABC && add |-> ##2
		p_o == $past(p_o) + $past(ab, 2) + $past(c_i, 2) + $past(carry_in_i, 2))
		else $error("accumulate add result wrong");
	a_acc_ab_carry: assert property (fab && op == CSA_OPSEL_ACC_AB && add |-> ##2
		{cascaded_carry_out_o, p_o} == {1'b0, $past(p_o)} + $past(ab, 2) + $past(carry_in_i, 2))
		else $error("accumulate without C wrong");
	a_wide_add: assert property (piped && op == 7'h33 && casc && add |-> ##2
		{cascaded_carry_out_o, p_o} == {1'b0, $past(c_i, 2)} + $past(ab, 2) +
		$past(carry_cascade_in_i))
		else $error("chained add wrong");
	a_wide_sub: assert property (fab && op == 7'h33 && sub |-> ##2
		p_o == $past(c_i, 2) - ($past(ab, 2) + $past(carry_in_i, 2)))
		else $error("chained subtract wrong");
	a_reset_clear: assert property (disable iff (1'b0) !rst_n_i |=>
		p_o == CSA_P_RST && !cascaded_carry_out_o && flags_o == '0)
		else $error("reset left state behind");
	a_ovf_flags: assert property ($past(rst_n_i) |->
		flags_o.overflow == ($past(p_o[47]) == $past(p_o[46]) && p_o[47:46] == 2'b01) &&
		flags_o.underflow == ($past(p_o[47]) == $past(p_o[46]) && p_o[47:46] == 2'b10))
		else $error("overflow flags wrong");
	a_pattern_match: assert property ($past(rst_n_i) && $stable(pattern_i) && $stable(mask_i) |->
		flags_o.pattern_match == (((p_o ^ pattern_i) & ~mask_i) == 48'h0))
		else $error("pattern match wrong");
	a_ext_lock: assert property (OPSEL_REG == 1 |-> !flags_o.multiply_accumulate_ext_active)
		else $error("extension active with registered codes");
	a_ext_add: assert property (OPSEL_REG == 0 && CISEL_REG == 0 && op == CSA_OPSEL_MULTIPLY_ACCUMULATE_EXT &&
		casc && flags_o.multiply_accumulate_ext_active |=> p_o == $past(p_o) +
		{48{$past(product_sign_cascade_i)}} + $past(carry_cascade_in_i))
		else $error("extension sum wrong");
endmodule

bind csa_slice csa_slice_sva #(.OPSEL_REG(OPSEL_REG), .CISEL_REG(CISEL_REG)) csa_slice_sva_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .a_i(a_i), .b_i(b_i), .c_i(c_i), .carry_in_i(carry_in_i),
	.ctrl_i(ctrl_i), .carry_cascade_in_i(carry_cascade_in_i),
	.product_sign_cascade_i(product_sign_cascade_i), .pattern_i(pattern_i), .mask_i(mask_i),
	.p_o(p_o), .cascaded_carry_out_o(cascaded_carry_out_o), .flags_o(flags_o));

// File: csa_far.sv
// far-side model: cascade outputs of a lower slice
`timescale 1ns/1ns
module csa_far
	import csa_pkg::*;
(
	input wire logic clk_i, // clock
	output logic [CSA_P_W-1:0] pcin_o, // cascaded result
	output logic carry_o, // cascaded carry
	output logic sign_o // product sign
);
	int seed = 43856;
	// a busy lower slice draws new random cascade values every cycle; the one-bit carry and sign repeat half the time
	initial begin
		pcin_o = '0;
		carry_o = 1'b0;
		sign_o = 1'b0;
	end
	always @(posedge clk_i) begin
		pcin_o <= 48'({$random(seed), $random(seed)});
		carry_o <= 1'($random(seed));
		sign_o <= 1'($random(seed));
	end
endmodule

// File: tb.sv
// self-checking bench for the cascadable slice datapath
`timescale 1ns/1ns
module tb;
	import csa_pkg::*;
	logic clk_i, rst_n_i, carry_in_i, cc, ps, rq, cs, sg, ca, pso;
	logic [CSA_A_W-1:0] a_i;
	logic [CSA_B_W-1:0] b_i;
	logic [47:0] c_i, pattern_i, mask_i, pcin, p_o, p_x, exp, exp_x, s_ab, s_c;
	logic co, s_ci;
	logic [49:0] r;
	csa_ctrl_t ctrl_i, ctrl_x, s_ctrl, k;
	csa_flags_t fl_x;
	int seed = 43856;
	int err_count = 0;
	int samples_checked = 0;
	// 7'h33 is the chained wide add: C plus A:B
	localparam logic [6:0] OPS [4] = '{CSA_OPSEL_ACC_ABC, CSA_OPSEL_ACC_AB, 7'h33, 7'h2F};

	csa_slice csa_slice_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .a_i(a_i), .b_i(b_i), .c_i(c_i),
		.carry_in_i(carry_in_i), .ctrl_i(ctrl_i), .pcin_i(pcin), .carry_cascade_in_i(cc),
		.product_sign_cascade_i(ps), .pattern_i(pattern_i), .mask_i(mask_i), .p_o(p_o),
		.cascaded_carry_out_o(co), .product_sign_cascade_o(pso), .flags_o());
	// upper slice extending a lower one; its codes act without a register
	// both slices share the same A and B stages and the default one-stage A:B
	csa_slice #(.OPSEL_REG(0), .CISEL_REG(0)) csa_slice_ext_inst (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .a_i(a_i), .b_i(b_i), .c_i(c_i), .carry_in_i(carry_in_i),
		.ctrl_i(ctrl_x), .pcin_i(pcin), .carry_cascade_in_i(cc), .product_sign_cascade_i(ps),
		.pattern_i(pattern_i), .mask_i(mask_i), .p_o(p_x), .cascaded_carry_out_o(),
		.product_sign_cascade_o(), .flags_o(fl_x));
	csa_far csa_far_inst (.clk_i(clk_i), .pcin_o(pcin), .carry_o(cc), .sign_o(ps));

	// expected sum for the codes in use; bit 48 is the add carry
	function automatic logic [49:0] nxt_res(csa_ctrl_t q, logic [47:0] p, ab, c, logic ci, cas);
		logic [49:0] x, y, z, i;
		x = q.operand_select_code[1:0] == CSA_X_AB ? {2'b0, ab} : 50'h0;
		y = q.operand_select_code[3:2] == CSA_Y_C ? {2'b0, c} : 50'h0;
		z = q.operand_select_code[6:4] == CSA_Z_P ? {2'b0, p} :
			q.operand_select_code[6:4] == CSA_Z_C ? {2'b0, c} : 50'h0;
		i = q.carry_in_source_select == CSA_CI_CASCADE ? 50'(cas) : 50'(ci);
		return q.arith_function_code == CSA_ALU_SUB ? z - (x + y + i) : z + x + y + i;
	endfunction

	// compare tasks, counted
	task automatic chk_word(string n, logic [47:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_bit(string n, logic e, g);
		chk_word(n, 48'(e), 48'(g));
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// reset, then random traffic with corners first and a reset in mid-run
	initial begin
		{rst_n_i, carry_in_i, a_i, b_i, c_i} = '0;
		ctrl_i = '0;
		ctrl_x = '{CSA_OPSEL_MULTIPLY_ACCUMULATE_EXT, CSA_ALU_ADD, CSA_CI_CASCADE};
		pattern_i = 48'h0;
		mask_i = 48'hFFFF_FFFF_FFF0;
		{exp, exp_x, s_ab, s_c, s_ci} = '0;
		s_ctrl = '0;
		for (int n = 0; n < 600; n++) begin
			@(negedge clk_i);
			rq = rst_n_i;
			cs = cc;
			sg = ps;
			@(posedge clk_i);
			ca = rq && s_ctrl.arith_function_code == CSA_ALU_ADD;
			r = nxt_res(s_ctrl, exp, s_ab, s_c, s_ci, cs);
			exp = rq ? r[47:0] : '0;
			exp_x = rq ? exp_x + {48{sg}} + 48'(cs) : '0;
			s_ctrl = rq ? ctrl_i : '0;
			s_ab = 48'({a_i, b_i});
			s_c = c_i;
			s_ci = rq ? carry_in_i : 1'b0;
			rst_n_i <= n >= 20 && n != 300 && n != 301;
			// operands change freely: no dynamic complex combining cycle is used here
			a_i <= n < 40 ? '1 : 25'($random(seed));
			b_i <= n < 40 ? '1 : 18'($random(seed));
			c_i <= n < 40 ? '1 : 48'({$random(seed), $random(seed)});
			carry_in_i <= 1'($random(seed));
			k.operand_select_code = n < 40 ? CSA_OPSEL_ACC_ABC : OPS[2'($random(seed))];
			k.arith_function_code = (n < 40 ? n[0] : $random(seed) & 1) ? CSA_ALU_SUB : CSA_ALU_ADD;
			k.carry_in_source_select = $random(seed) & 1 ? CSA_CI_CASCADE : CSA_CI_FABRIC;
			ctrl_i <= k;
			#1;
			chk_word("result", exp, p_o);
			if (ca) chk_bit("carry out", r[48], co);
			chk_word("extended result", exp_x, p_x);
			chk_bit("sign cascade", 1'b0, pso);
			chk_bit("extension active", rq, fl_x.multiply_accumulate_ext_active);
		end
		tally_and_finish();
	end
endmodule
